// ===== osc_clk_defines.svh
/*
 * offsets, field positions, reset values and timing counts of the internal
 * oscillator clock controller.
 * assumes a 100 MHz bus clock; register indices are word indices.
 */
`ifndef OSC_CLK_DEFINES_SVH
`define OSC_CLK_DEFINES_SVH

// register indices; byte address is four times the index
`define CTRL_INDEX       8'h8a
`define TRIM_INDEX       8'h8b
`define CSEL_INDEX       8'h8c
`define MCD_INDEX        8'h8d
`define REG_ADDR(idx)    {2'h0, idx, 2'h0}

// register fields and reset values
`define CTRL_EN_BIT      7
`define CTRL_RDY_BIT     6
`define CTRL_RESET       8'hc0
`define TRIM_RESET       8'hfb
`define CSEL_RESET       1'h0
`define MCD_EN_BIT       0
`define MCD_FLAG_BIT     1

// internal oscillator model: tick rate = bus clock * trim / 2**ACC_W
`define ACC_W            10
`define OSC_SETTLE_TICKS 4'h8

// bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// timing
`define CLK_PERIOD_NS    10
`define MCD_TIMEOUT_US   220
`define MCD_MIN_US       100
`define MCD_MAX_US       500
`define MCD_TIMEOUT_CYC  ((`MCD_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define MCD_CNT_W        16

`endif

// ===== osc_clk_pkg.sv
/*
 * types of the internal oscillator clock controller.
 * assumes osc_clk_defines.svh is compiled alongside.
 */
`include "osc_clk_defines.svh"

package osc_clk_pkg;

    typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_TRIM, SEL_CSEL, SEL_MCD} reg_sel_t;

    typedef struct packed {
        logic [`ACC_W-1:0] acc;
        logic              tick;
    } osc_state_t;

    typedef struct packed {
        logic                  osc_en;
        logic                  ready;
        logic [1:0]            div_sel;
        logic [7:0]            trim;
        logic                  clk_src;
        logic                  mcd_en;
        logic                  mcd_flag;
        logic [3:0]            settle;
        logic [2:0]            div_cnt;
        logic                  core_tick;
        logic [`MCD_CNT_W-1:0] mcd_cnt;
        logic                  reset_req;
    } clk_state_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [11:0] waddr;
        logic [7:0]  wdata;
        logic        wlane;
    } axi_state_t;

    typedef struct packed {
        clk_state_t clk;
        axi_state_t axi;
    } top_state_t;

endpackage : osc_clk_pkg

// ===== int_osc_model.sv
/*
 * programmable internal oscillator, modelled as a phase accumulator that
 * issues one tick per oscillator period.
 * assumes the caller holds trim steady between writes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "osc_clk_defines.svh"

module int_osc_model (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       run,
    input  wire logic [7:0] trim,
    // oscillator period tick
    output var  logic       tick
);

    osc_clk_pkg::osc_state_t s;
    osc_clk_pkg::osc_state_t next_s;
    logic [`ACC_W:0]         sum;

    // an 8-bit trim against a 10-bit accumulator caps the rate below a quarter of aclk
    always_comb begin
        sum    = {1'b0, s.acc} + {3'h0, trim};
        next_s = s;
        next_s.tick = 1'b0;
        if (run) begin
            next_s.acc  = sum[`ACC_W-1:0];
            next_s.tick = sum[`ACC_W];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule : int_osc_model
`default_nettype wire

// ===== int_osc_clock_divider.sv
/*
 * internal oscillator control, core clock divider, clock source select and
 * missing clock detector behind an AXI4-Lite register slave.
 * assumes ext_osc_tick and ext_osc_valid are synchronous to aclk.
 */
// Added by the designer: the AXI4-Lite slave port.
//
// Function
// - after reset the internal oscillator is the core clock source.
// - a writable trim sets the oscillator period; reset value gives 24.5 MHz.
// - divide select 00 by 8, 01 by 4, 10 by 2, 11 by 1.
// - control bit 7 enables the oscillator; reads 1 after reset.
// - enabled missing clock detector requests reset after timeout without core tick.
// - source select 1 external, 0 internal; switch only to settled sources.
`timescale 1ns/1ps
`default_nettype none
`include "osc_clk_defines.svh"

module int_osc_clock_divider #(
    parameter int MCD_TIMEOUT = `MCD_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [11:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [11:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    // external oscillator
    input  wire logic        ext_osc_tick,
    input  wire logic        ext_osc_valid,
    // clock outputs
    output var  logic        core_clk_en,
    output var  logic        clock_source,
    output var  logic        osc_running,
    output var  logic        mcd_reset_req
);

    localparam logic [`MCD_CNT_W-1:0] MCD_LAST = `MCD_CNT_W'(MCD_TIMEOUT - 1);
    localparam logic [7:0]            CTRL_RST = `CTRL_RESET;

    osc_clk_pkg::top_state_t s;
    osc_clk_pkg::top_state_t next_s;
    osc_clk_pkg::reg_sel_t   wsel;
    osc_clk_pkg::reg_sel_t   rsel;
    logic                    osc_tick;
    logic                    wr_go;
    logic                    wr_en;
    logic [7:0]              wd;

    function automatic osc_clk_pkg::reg_sel_t decode(input logic [11:0] a);
        case (a)
            `REG_ADDR(`CTRL_INDEX): decode = osc_clk_pkg::SEL_CTRL;
            `REG_ADDR(`TRIM_INDEX): decode = osc_clk_pkg::SEL_TRIM;
            `REG_ADDR(`CSEL_INDEX): decode = osc_clk_pkg::SEL_CSEL;
            `REG_ADDR(`MCD_INDEX):  decode = osc_clk_pkg::SEL_MCD;
            default:                decode = osc_clk_pkg::SEL_NONE;
        endcase
    endfunction : decode

    // mask of divider counter bits that must all be set for a core tick
    function automatic logic [2:0] divide_mask(input logic [1:0] sel);
        case (sel)
            2'h0:    divide_mask = 3'h7;
            2'h1:    divide_mask = 3'h3;
            2'h2:    divide_mask = 3'h1;
            default: divide_mask = 3'h0;
        endcase
    endfunction : divide_mask

    int_osc_model u_osc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (s.clk.osc_en),
        .trim    (s.clk.trim),
        .tick    (osc_tick)
    );

    assign wsel  = decode(s.axi.waddr);
    assign rsel  = decode(araddr);
    assign wr_go = !s.axi.awready && !s.axi.wready && !s.axi.bvalid;
    assign wr_en = wr_go && s.axi.wlane;
    assign wd    = s.axi.wdata;

    always_comb begin
        next_s = s;
        next_s.clk.core_tick = 1'b0;
        next_s.clk.reset_req = 1'b0;

        // write address and data are taken independently, in either order
        if (awvalid && s.axi.awready) begin
            next_s.axi.awready = 1'b0;
            next_s.axi.waddr   = awaddr;
        end
        if (wvalid && s.axi.wready) begin
            next_s.axi.wready = 1'b0;
            next_s.axi.wdata  = wdata[7:0];
            next_s.axi.wlane  = wstrb[0];
        end
        if (wr_go) begin
            next_s.axi.bvalid = 1'b1;
            next_s.axi.bresp  = (wsel == osc_clk_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (s.axi.bvalid && bready) begin
            next_s.axi.bvalid  = 1'b0;
            next_s.axi.awready = 1'b1;
            next_s.axi.wready  = 1'b1;
        end

        if (arvalid && s.axi.arready) begin
            next_s.axi.arready = 1'b0;
            next_s.axi.rvalid  = 1'b1;
            next_s.axi.rresp   = `RESP_OKAY;
            next_s.axi.rdata   = 32'h0;
            case (rsel)
                osc_clk_pkg::SEL_CTRL: next_s.axi.rdata[7:0] =
                    {s.clk.osc_en, s.clk.ready, 4'h0, s.clk.div_sel};
                osc_clk_pkg::SEL_TRIM: next_s.axi.rdata[7:0] = s.clk.trim;
                osc_clk_pkg::SEL_CSEL: next_s.axi.rdata[0] = s.clk.clk_src;
                osc_clk_pkg::SEL_MCD:  next_s.axi.rdata[1:0] = {s.clk.mcd_flag, s.clk.mcd_en};
                default:               next_s.axi.rresp = `RESP_SLVERR;
            endcase
        end
        if (s.axi.rvalid && rready) begin
            next_s.axi.rvalid  = 1'b0;
            next_s.axi.arready = 1'b1;
        end

        // register write effects; the ready bit and reserved bits ignore writes
        if (wr_en) begin
            case (wsel)
                osc_clk_pkg::SEL_CTRL: begin
                    next_s.clk.osc_en  = wd[`CTRL_EN_BIT];
                    next_s.clk.div_sel = wd[1:0];
                    if (wd[`CTRL_EN_BIT] != s.clk.osc_en) begin
                        next_s.clk.settle = 4'h0;
                    end
                end
                osc_clk_pkg::SEL_TRIM: begin
                    next_s.clk.trim   = wd;
                    next_s.clk.settle = 4'h0;
                end
                osc_clk_pkg::SEL_CSEL: begin
                    // a request toward an unsettled source is dropped
                    if (wd[0] && ext_osc_valid) begin
                        next_s.clk.clk_src = 1'b1;
                    end else if (!wd[0] && s.clk.osc_en && s.clk.ready) begin
                        next_s.clk.clk_src = 1'b0;
                    end
                end
                osc_clk_pkg::SEL_MCD: begin
                    next_s.clk.mcd_en = wd[`MCD_EN_BIT];
                    if (wd[`MCD_FLAG_BIT]) begin
                        next_s.clk.mcd_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (osc_tick && next_s.clk.settle != `OSC_SETTLE_TICKS) begin
            next_s.clk.settle = next_s.clk.settle + 4'h1;
        end
        next_s.clk.ready = next_s.clk.osc_en && (next_s.clk.settle == `OSC_SETTLE_TICKS);

        if (osc_tick) begin
            next_s.clk.div_cnt = s.clk.div_cnt + 3'h1;
        end
        if (!s.clk.clk_src) begin
            next_s.clk.core_tick = osc_tick &&
                ((s.clk.div_cnt & divide_mask(s.clk.div_sel)) == divide_mask(s.clk.div_sel));
        end else begin
            next_s.clk.core_tick = ext_osc_tick;
        end

        // counts cycles since the last core tick; the flag set wins over a clear
        if (!s.clk.mcd_en || s.clk.core_tick) begin
            next_s.clk.mcd_cnt = '0;
        end else if (s.clk.mcd_cnt == MCD_LAST) begin
            next_s.clk.mcd_cnt   = '0;
            next_s.clk.reset_req = 1'b1;
            next_s.clk.mcd_flag  = 1'b1;
        end else begin
            next_s.clk.mcd_cnt = s.clk.mcd_cnt + `MCD_CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s                 <= '0;
            s.clk.osc_en      <= CTRL_RST[`CTRL_EN_BIT];
            s.clk.ready       <= CTRL_RST[`CTRL_RDY_BIT];
            s.clk.settle      <= `OSC_SETTLE_TICKS;
            s.clk.trim        <= `TRIM_RESET;
            s.clk.clk_src     <= `CSEL_RESET;
            s.axi.awready     <= 1'b1;
            s.axi.wready      <= 1'b1;
            s.axi.arready     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign awready       = s.axi.awready;
    assign wready        = s.axi.wready;
    assign bvalid        = s.axi.bvalid;
    assign bresp         = s.axi.bresp;
    assign arready       = s.axi.arready;
    assign rvalid        = s.axi.rvalid;
    assign rresp         = s.axi.rresp;
    assign rdata         = s.axi.rdata;
    assign core_clk_en   = s.clk.core_tick;
    assign clock_source  = s.clk.clk_src;
    assign osc_running   = s.clk.osc_en;
    assign mcd_reset_req = s.clk.reset_req;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reset_source_a: assert property ($rose(aresetn) |-> !clock_source && osc_running)
        else $error("internal oscillator not selected after reset");
    trim_rate_a: assert property (osc_tick |=> (!osc_tick) [*3])
        else $error("oscillator ticks closer than four bus cycles");
    div_by_one_a: assert property (
        (osc_tick && !s.clk.clk_src && s.clk.div_sel == 2'h3) |=> core_clk_en)
        else $error("divide by one missed a core tick");
    // a source switch or a new divide select may legally bring the next tick early
    div_by_eight_a: assert property (
        (core_clk_en && !clock_source && !$past(clock_source) && s.clk.div_sel == 2'h0
        && $stable(s.clk.div_sel))
        |=> (!core_clk_en || clock_source || s.clk.div_sel != 2'h0) [*8])
        else $error("divide by eight ticked too soon");
    disable_stops_a: assert property (!osc_running |=> !osc_tick)
        else $error("oscillator ticked while disabled");
    mcd_fire_a: assert property (
        (s.clk.mcd_en && !s.clk.core_tick && s.clk.mcd_cnt == MCD_LAST)
        |=> mcd_reset_req && s.clk.mcd_flag)
        else $error("missing clock timeout gave no reset");
    mcd_quiet_a: assert property (mcd_reset_req |-> !$past(core_clk_en))
        else $error("reset raised right after a core tick");
    ready_off_a: assert property (!osc_running |-> !s.clk.ready)
        else $error("ready flag set while oscillator disabled");
    switch_guard_a: assert property ($rose(clock_source) |-> $past(ext_osc_valid))
        else $error("switched to an unsettled external source");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped before acceptance");

    ext_tick_c: cover property (clock_source && core_clk_en);
    mcd_reset_c: cover property (mcd_reset_req);
    ready_rise_c: cover property ($rose(s.clk.ready));
    back_to_int_c: cover property ($fell(clock_source));

endmodule : int_osc_clock_divider
`default_nettype wire

// ===== tb.sv
/*
 * self-checking bench for the internal oscillator clock controller.
 * assumes osc_clk_defines.svh is on the include path; the bench drives
 * the axi4-lite slave and the external oscillator inputs itself.
 */
`timescale 1ns/1ps
`default_nettype none
`include "osc_clk_defines.svh"

module tb;
    // clock and reset
    logic        aclk;
    logic        aresetn;
    // axi4-lite
    logic [11:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    // external oscillator and outputs
    logic        ext_osc_tick;
    logic        ext_osc_valid;
    logic        ext_run;
    logic [2:0]  ext_cnt;
    logic        core_clk_en;
    logic        clock_source;
    logic        osc_running;
    logic        mcd_reset_req;
    int          n_mismatch;
    int          checks;

    localparam logic [11:0] CTRL = `REG_ADDR(`CTRL_INDEX);
    localparam logic [11:0] TRIM = `REG_ADDR(`TRIM_INDEX);
    localparam logic [11:0] CSEL = `REG_ADDR(`CSEL_INDEX);
    localparam logic [11:0] MCD  = `REG_ADDR(`MCD_INDEX);

    int_osc_clock_divider #(.MCD_TIMEOUT(64)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_osc_tick(ext_osc_tick), .ext_osc_valid(ext_osc_valid),
        .core_clk_en(core_clk_en), .clock_source(clock_source),
        .osc_running(osc_running), .mcd_reset_req(mcd_reset_req)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // external oscillator: one tick every 5 bus cycles (20 MHz)
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_cnt      <= 3'h0;
            ext_osc_tick <= 1'b0;
        end else begin
            ext_cnt      <= (ext_cnt == 3'h4) ? 3'h0 : ext_cnt + 3'h1;
            ext_osc_tick <= ext_run && (ext_cnt == 3'h4);
        end
    end

    // wide enough for a response code above a data word
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // sampling at the falling edge shows what the next rising edge takes
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        logic a_ok;
        logic w_ok;
        logic a_done;
        logic w_done;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        a_done = 1'b0;
        w_done = 1'b0;
        // the valids only update after this time step, so handshakes are tracked here
        while (!a_done || !w_done) begin
            @(negedge aclk);
            a_ok = awready && !a_done;
            w_ok = wready && !w_done;
            @(posedge aclk);
            if (a_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            a_done = a_done || a_ok;
            w_done = w_done || w_ok;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic a_ok;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge aclk);
            a_ok = arready;
            @(posedge aclk);
        end while (!a_ok);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d    = rdata;
        resp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd

    task automatic count(input int n, output int c, output int m);
        c = 0;
        m = 0;
        repeat (n) begin
            @(negedge aclk);
            c += (core_clk_en === 1'b1);
            m += (mcd_reset_req === 1'b1);
        end
    endtask : count

    task automatic wait_ready;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        d = '0;
        while (d[`CTRL_RDY_BIT] !== 1'b1 && n < 40) begin
            rd(CTRL, d, r);
            n++;
        end
        check(d[`CTRL_RDY_BIT], 1'b1);
    endtask : wait_ready

    function automatic logic near(input int c, input int e);
        return (c + 1 >= e) && (c <= e + 1);
    endfunction : near

    task automatic t_reset_and_map;
        logic [31:0] d;
        logic [1:0]  r;
        check(clock_source, 1'b0);
        check(osc_running, 1'b1);
        rd(CTRL, d, r);
        check(d, 32'h000000c0);
        rd(TRIM, d, r);
        check(d, 32'h000000fb);
        rd(CSEL, d, r);
        check(d, 32'h00000000);
        rd(MCD, d, r);
        check({r, d}, {`RESP_OKAY, 32'h00000000});
        rd(12'h000, d, r);
        check({r, d}, {`RESP_SLVERR, 32'h00000000});
        wr(12'h000, 32'h000000ff, 4'hf, r);
        check(r, `RESP_SLVERR);
    endtask : t_reset_and_map

    task automatic t_divide;
        logic [1:0] r;
        int         c;
        int         m;
        for (int d = 0; d < 4; d++) begin
            wr(CTRL, 32'h80 | d, 4'h1, r);
            wait_ready();
            count(4096, c, m);
            check(near(c, 1004 / (8 >> d)), 1'b1);
        end
    endtask : t_divide

    task automatic t_trim;
        logic [31:0] d;
        logic [1:0]  r;
        int          c;
        int          m;
        wr(TRIM, 32'h00000080, 4'h1, r);
        rd(CTRL, d, r);
        check(d, 32'h00000083);
        rd(TRIM, d, r);
        check(d, 32'h00000080);
        wait_ready();
        count(4096, c, m);
        check(near(c, 512), 1'b1);
        wr(TRIM, 32'h00000055, 4'h0, r);
        rd(TRIM, d, r);
        check({r, d}, {`RESP_OKAY, 32'h00000080});
        wr(TRIM, 32'h000000fb, 4'h1, r);
        wr(CTRL, 32'h00000080, 4'h1, r);
        wait_ready();
    endtask : t_trim

    task automatic t_mcd;
        logic [31:0] d;
        logic [1:0]  r;
        int          c;
        int          m;
        wr(MCD, 32'h00000001, 4'h1, r);
        count(300, c, m);
        check(m, 0);
        wr(CTRL, 32'h00000003, 4'h1, r);
        rd(CTRL, d, r);
        check(d, 32'h00000003);
        check(osc_running, 1'b0);
        count(100, c, m);
        check(c, 0);
        check(m >= 1 && m <= 2, 1'b1);
        rd(MCD, d, r);
        check(d, 32'h00000003);
        // stop the detector before clearing, so a timeout cannot land on the clear
        wr(MCD, 32'h00000000, 4'h1, r);
        rd(MCD, d, r);
        check(d, 32'h00000002);
        wr(MCD, 32'h00000002, 4'h1, r);
        rd(MCD, d, r);
        check(d, 32'h00000000);
        wr(CTRL, 32'h00000080, 4'h1, r);
        wait_ready();
    endtask : t_mcd

    task automatic t_source;
        logic [31:0] d;
        logic [1:0]  r;
        int          c;
        int          m;
        wr(CSEL, 32'h00000001, 4'h1, r);
        repeat (2) @(negedge aclk);
        check(clock_source, 1'b0);
        @(posedge aclk);
        ext_osc_valid <= 1'b1;
        ext_run       <= 1'b1;
        wr(CSEL, 32'h00000001, 4'h1, r);
        repeat (2) @(negedge aclk);
        check(clock_source, 1'b1);
        count(500, c, m);
        check(near(c, 100), 1'b1);
        wr(CTRL, 32'h00000000, 4'h1, r);
        wr(CSEL, 32'h00000000, 4'h1, r);
        rd(CSEL, d, r);
        check(d, 32'h00000001);
        wr(CTRL, 32'h00000080, 4'h1, r);
        wait_ready();
        wr(CSEL, 32'h00000000, 4'h1, r);
        repeat (2) @(negedge aclk);
        check(clock_source, 1'b0);
    endtask : t_source

    // reset in mid-run from the external source with a changed trim
    task automatic t_rereset;
        logic [31:0] d;
        logic [1:0]  r;
        wr(TRIM, 32'h000000c0, 4'h1, r);
        wr(CSEL, 32'h00000001, 4'h1, r);
        repeat (2) @(negedge aclk);
        check(clock_source, 1'b1);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check(clock_source, 1'b0);
        check(osc_running, 1'b1);
        rd(CTRL, d, r);
        check(d, 32'h000000c0);
        rd(TRIM, d, r);
        check(d, 32'h000000fb);
    endtask : t_rereset

    initial begin
        n_mismatch    = 0;
        checks        = 0;
        aresetn       = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        {ext_osc_valid, ext_run} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        t_reset_and_map();
        t_divide();
        t_trim();
        t_mcd();
        t_source();
        t_rereset();
        summarize();
    end

    // the tests take about 22k cycles; a hang is cut off well after that
    initial begin
        repeat (60000) @(posedge aclk);
        n_mismatch++;
        summarize();
    end
endmodule : tb

`default_nettype wire
